/* File: dsip_serial_port.v */
// dsip_serial_port.v: serial input, decode, register file and readback of the converter
// assumes frame select, serial clock, data and load arrive from pins, asynchronous to mclk
// assumes mclk is fast enough to see every serial clock phase (at least 2 cycles each)
`timescale 1ns/100ps
`include "dsip_map.vh"

// Behaviour
// - 24-bit frames, MSB first, shifted in
// - bit 23 read flag, 22:20 address, data
// - address 000 is no-operation
// - write flag addresses code, control, clear, software
// - read flag selects code, control, clearcode readback
// - frame starts on select falling edge
// - wrong edge count leaves registers unchanged
// - select rising latches word into register
// - load low with select high updates output
// - extra bits pass through to output
// - output driven on rising, sampled falling
// - select rising stops shifting, latches word
// - next 24 clocks shift read data out
// - output high impedance while select high
// - next read addressed while shifting previous
// - readback needs output enabled, default enabled
// - six MSBs to 63 segments, ten to ladder
// - load held low updates on select rising
module dsip_serial_port (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // serial link pins
  input wire frameSelN,
  input wire serialClk,
  input wire serialInLine,
  output reg serialOutLine,
  output wire serialOutOe,
  // hardware control pins
  input wire outputLoadN,
  input wire chainMode,
  // register contents
  output reg [15:0] dacCode,
  output reg [15:0] codeWord,
  output reg [19:0] controlWord,
  output reg [15:0] clearcodeWord,
  output reg [19:0] swCtrlWord,
  output reg swCtrlStrobe,
  output reg frameError,
  // converter switch controls
  output wire [62:0] segmentSw,
  output wire [9:0] ladderSw
);

  // synchronisers: stage one feeds stage two only
  reg [1:0] frameSync1Q;
  reg frameSyncQ;
  reg sclkSync1Q;
  reg sclkSyncQ;
  reg sdinSync1Q;
  reg sdinSyncQ;
  reg loadSync1Q;
  reg loadSyncQ;
  reg chainSync1Q;
  reg chainSyncQ;
  reg frameDlyQ;
  reg sclkDlyQ;

  // frame state
  reg [23:0] shiftQ;
  reg [4:0] phaseQ;
  reg reachedQ;
  reg overQ;
  reg inFrameQ;
  reg loadSeenQ;

  // readback state
  reg readPendQ;
  reg [2:0] readAddrQ;

  wire frameFall;
  wire frameRise;
  wire sclkFall;
  wire sclkRise;
  wire frameValid;
  wire wordRead;
  wire [2:0] wordAddr;
  wire [19:0] wordData;
  wire outEnabled;
  reg [23:0] readWord;

  // two-flop synchronisers for each pin input, three flops for frame select
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frameSync1Q <= 2'h3;
      frameSyncQ <= 1'b1;
      sclkSync1Q <= 1'b0;
      sclkSyncQ <= 1'b0;
      sdinSync1Q <= 1'b0;
      sdinSyncQ <= 1'b0;
      loadSync1Q <= 1'b1;
      loadSyncQ <= 1'b1;
      chainSync1Q <= 1'b0;
      chainSyncQ <= 1'b0;
      frameDlyQ <= 1'b1;
      sclkDlyQ <= 1'b0;
    end else begin
      frameSync1Q <= {frameSync1Q[0], frameSelN};
      frameSyncQ <= frameSync1Q[1];
      sclkSync1Q <= serialClk;
      sclkSyncQ <= sclkSync1Q;
      sdinSync1Q <= serialInLine;
      sdinSyncQ <= sdinSync1Q;
      loadSync1Q <= outputLoadN;
      loadSyncQ <= loadSync1Q;
      chainSync1Q <= chainMode;
      chainSyncQ <= chainSync1Q;
      frameDlyQ <= frameSyncQ;
      sclkDlyQ <= sclkSyncQ;
    end
  end

  // edge detection on the synchronised link signals
  // frame start edge
  assign frameFall = frameDlyQ & ~frameSyncQ;
  assign frameRise = ~frameDlyQ & frameSyncQ;
  assign sclkFall = sclkDlyQ & ~sclkSyncQ;
  assign sclkRise = ~sclkDlyQ & sclkSyncQ;

  // latched word fields
  // field split
  assign wordRead = shiftQ[`DSIP_RW_BIT];
  assign wordAddr = shiftQ[`DSIP_ADDR_HI:`DSIP_ADDR_LO];
  assign wordData = shiftQ[`DSIP_DATA_HI:`DSIP_DATA_LO];

  assign frameValid = inFrameQ & reachedQ & (chainSyncQ ? (phaseQ == 5'h00) : ~overQ);

  assign outEnabled = ~controlWord[`DSIP_CTRL_OUTDIS_BIT];

  assign serialOutOe = ~frameSyncQ & outEnabled;

  // readback word for the addressed register
  // readable registers
  always @* begin
    readWord = 24'h000000;
    case (readAddrQ)
      `DSIP_ADDR_CODE: begin
        readWord = {1'b1, readAddrQ, codeWord, 4'h0};
      end
      `DSIP_ADDR_CTRL: begin
        readWord = {1'b1, readAddrQ, controlWord};
      end
      `DSIP_ADDR_CLEAR: begin
        readWord = {1'b1, readAddrQ, clearcodeWord, 4'h0};
      end
      default: begin
        readWord = 24'h000000;
      end
    endcase
  end

  // shift register, edge counter and serial output
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shiftQ <= 24'h000000;
      phaseQ <= 5'h00;
      reachedQ <= 1'b0;
      overQ <= 1'b0;
      inFrameQ <= 1'b0;
      serialOutLine <= 1'b0;
    end else if (frameFall) begin
      phaseQ <= 5'h00;
      reachedQ <= 1'b0;
      overQ <= 1'b0;
      inFrameQ <= 1'b1;
      if (readPendQ && outEnabled) begin
        shiftQ <= readWord;
        serialOutLine <= readWord[23];
      end else begin
        shiftQ <= 24'h000000;
        serialOutLine <= 1'b0;
      end
    end else if (frameRise) begin
      inFrameQ <= 1'b0;
    end else if (inFrameQ && !frameSyncQ) begin
      if (sclkFall) begin
        shiftQ <= {shiftQ[22:0], sdinSyncQ};
        if (phaseQ == 5'd23) begin
          phaseQ <= 5'h00;
          reachedQ <= 1'b1;
        end else begin
          phaseQ <= phaseQ + 5'h01;
        end
        if (reachedQ) begin
          overQ <= 1'b1;
        end
      end
      if (sclkRise) begin
        serialOutLine <= shiftQ[23];
      end
    end
  end

  // note whether load was held low at any point of the frame
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      loadSeenQ <= 1'b0;
    end else if (frameFall) begin
      loadSeenQ <= ~loadSyncQ;
    end else if (inFrameQ && !loadSyncQ) begin
      loadSeenQ <= 1'b1;
    end
  end

  // register writes and readback arming on frame end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      codeWord <= `DSIP_CODE_RST;
      controlWord <= `DSIP_CTRL_RST;
      clearcodeWord <= `DSIP_CLEAR_RST;
      swCtrlWord <= `DSIP_SWCTRL_RST;
      swCtrlStrobe <= 1'b0;
      frameError <= 1'b0;
      readPendQ <= 1'b0;
      readAddrQ <= `DSIP_ADDR_NOP;
    end else begin
      swCtrlStrobe <= 1'b0;
      frameError <= 1'b0;
      if (frameFall) begin
        // pending read data has now been loaded for shifting, or dropped if serial output is disabled
        readPendQ <= 1'b0;
      end
      if (frameRise && inFrameQ) begin
        if (!frameValid) begin
          frameError <= 1'b1;
        end else if (wordAddr == `DSIP_ADDR_NOP) begin
          readPendQ <= 1'b0;
        end else if (wordRead) begin
          readPendQ <= 1'b1;
          readAddrQ <= wordAddr;
        end else begin
          case (wordAddr)
            `DSIP_ADDR_CODE: begin
              codeWord <= wordData[`DSIP_CODE_HI:`DSIP_CODE_LO];
            end
            `DSIP_ADDR_CTRL: begin
              controlWord <= wordData;
            end
            `DSIP_ADDR_CLEAR: begin
              clearcodeWord <= wordData[`DSIP_CODE_HI:`DSIP_CODE_LO];
            end
            `DSIP_ADDR_SWCTRL: begin
              swCtrlWord <= wordData;
              swCtrlStrobe <= 1'b1;
            end
            default: begin
              swCtrlStrobe <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // output code register update
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dacCode <= `DSIP_CODE_RST;
    end else if (frameRise && inFrameQ && frameValid && loadSeenQ && !wordRead
                 && wordAddr == `DSIP_ADDR_CODE) begin
      dacCode <= wordData[`DSIP_CODE_HI:`DSIP_CODE_LO];
    end else if (frameSyncQ && !inFrameQ && !loadSyncQ) begin
      dacCode <= codeWord;
    end
  end

  dsip_code_decode #(
    .SEG_BITS(`DSIP_SEG_BITS),
    .LADDER_BITS(`DSIP_LADDER_BITS)
  ) uDecode (
    .mclk(mclk),
    .resetn(resetn),
    .codeIn(dacCode),
    .segmentSw(segmentSw),
    .ladderSw(ladderSw)
  );

endmodule

/* File: dsip_map.vh */
// dsip_map.vh: constants for the converter serial input and readback port
// assumes inclusion by the port modules; definitions only
`ifndef DSIP_MAP_VH
`define DSIP_MAP_VH

// frame layout
`define DSIP_FRAME_BITS 24
`define DSIP_RW_BIT 23
`define DSIP_ADDR_HI 22
`define DSIP_ADDR_LO 20
`define DSIP_DATA_HI 19
`define DSIP_DATA_LO 0
`define DSIP_CODE_HI 19
`define DSIP_CODE_LO 4

// register address codes
`define DSIP_ADDR_NOP 3'h0
`define DSIP_ADDR_CODE 3'h1
`define DSIP_ADDR_CTRL 3'h2
`define DSIP_ADDR_CLEAR 3'h3
`define DSIP_ADDR_SWCTRL 3'h4

// control register field: serial output disable
`define DSIP_CTRL_OUTDIS_BIT 5

// reset values
`define DSIP_CODE_RST 16'h0000
`define DSIP_CTRL_RST 20'h00000
`define DSIP_CLEAR_RST 16'h0000
`define DSIP_SWCTRL_RST 20'h00000

// code decode split
`define DSIP_SEG_BITS 6
`define DSIP_LADDER_BITS 10

// link timing: fastest serial clock the host may run, in MHz
`define DSIP_SCLK_MAX_MHZ 35

`endif

/* File: dsip_code_decode.v */
// dsip_code_decode.v: splits the 16-bit code into segment and ladder switch controls
// assumes a code that is stable or registered in the mclk domain
`timescale 1ns/100ps
`include "dsip_map.vh"

module dsip_code_decode #(
  parameter SEG_BITS = `DSIP_SEG_BITS,
  parameter LADDER_BITS = `DSIP_LADDER_BITS
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // code in
  input wire [SEG_BITS+LADDER_BITS-1:0] codeIn,
  // switch controls out
  output reg [(1<<SEG_BITS)-2:0] segmentSw,
  output reg [LADDER_BITS-1:0] ladderSw
);

  localparam NSEG = (1 << SEG_BITS) - 1;

  wire [SEG_BITS-1:0] segCode;
  wire [NSEG-1:0] segDecode;

  assign segCode = codeIn[SEG_BITS+LADDER_BITS-1:LADDER_BITS];

  // thermometer decode: switch i closes when upper code exceeds i
  genvar i;
  generate
    for (i = 0; i < NSEG; i = i + 1) begin : gSeg
      // switch index at code width, so the compare stays the same size on both sides
      localparam [SEG_BITS-1:0] SEG_IDX = i;
      assign segDecode[i] = (segCode > SEG_IDX);
    end
  endgenerate

  // registered switch controls
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      segmentSw <= {NSEG{1'b0}};
      ladderSw <= {LADDER_BITS{1'b0}};
    end else begin
      segmentSw <= segDecode;
      ladderSw <= codeIn[LADDER_BITS-1:0];
    end
  end

endmodule

/* File: dsip_checker.sv */
// dsip_checker.sv: port assertions for the serial port
// assumes a bind onto dsip_serial_port in the bench
`timescale 1ns/100ps
module dsip_checker (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // link and hardware pins
  input wire frameSelN,
  input wire serialClk,
  input wire serialInLine,
  input wire serialOutLine,
  input wire serialOutOe,
  input wire outputLoadN,
  input wire chainMode,
  // register contents
  input wire [15:0] dacCode,
  input wire [15:0] codeWord,
  input wire [19:0] controlWord,
  input wire [15:0] clearcodeWord,
  input wire [19:0] swCtrlWord,
  input wire swCtrlStrobe,
  input wire frameError,
  // switch controls
  input wire [62:0] segmentSw,
  input wire [9:0] ladderSw
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // long enough for the pin synchroniser to settle
  sequence frameIdle;
    frameSelN[*5];
  endsequence
  sequence frameBusy;
    (!frameSelN)[*5];
  endsequence
  sequence loadHeld;
    (frameSelN && !outputLoadN)[*7];
  endsequence

  a_oe_idle: assert property (frameIdle |-> !serialOutOe)
    else $error("serial output driven while idle");
  a_oe_frame: assert property (frameBusy ##0 !controlWord[5] |-> serialOutOe)
    else $error("serial output not driven in frame");
  a_oe_disabled: assert property (controlWord[5] |-> !serialOutOe)
    else $error("serial output driven while disabled");
  a_seg_thermo: assert property (segmentSw ==
    (63'h7fff_ffff_ffff_ffff >> (7'd63 - $past(dacCode[15:10]))))
    else $error("segment controls wrong");
  a_ladder_copy: assert property (ladderSw == $past(dacCode[9:0]))
    else $error("ladder controls wrong");
  a_hold_frame: assert property ((!frameSelN)[*6] |->
    $stable({codeWord, controlWord, clearcodeWord}))
    else $error("register changed inside frame");
  a_error_nochange: assert property (frameError |->
    $stable({codeWord, controlWord, clearcodeWord, swCtrlWord}) ##1 !frameError)
    else $error("bad frame changed registers");
  a_strobe_after: assert property (swCtrlStrobe |-> $past(frameSelN, 3) ##1 !swCtrlStrobe)
    else $error("strobe outside frame end");
  a_load_level: assert property (loadHeld |-> dacCode == codeWord)
    else $error("load did not update output code");
endmodule

/* File: dsip_host_model.sv */
// dsip_host_model.sv: host serial controller driving gated frames
// assumes a 48 ns link clock and a bench that calls frame()
`timescale 1ns/100ps
module dsip_host_model (
  // link pins
  output logic frameSelN,
  output logic serialClk,
  output logic serialInLine,
  input wire logic serialOutLine
);
  // idle link: select high, clock still
  initial begin
    frameSelN = 1'b1;
    serialClk = 1'b0;
    serialInLine = 1'b0;
  end
  task automatic frame(input logic [47:0] w, input int n, output logic [47:0] rd);
    rd = 48'h0;
    frameSelN <= 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      serialClk <= 1'b1;
      serialInLine <= w[i];
      #24;
      // sample on fall, 48 ns period
      rd = {rd[46:0], serialOutLine};
      serialClk <= 1'b0;
      #24;
    end
    frameSelN <= 1'b1;
    serialInLine <= ~serialInLine; // released line shows no stale value
    #40;
  endtask
endmodule

/* File: dsip_tb.sv */
// dsip_tb.sv: self-checking bench for the serial port
// assumes dsip_checker and dsip_host_model are compiled first
`timescale 1ns/100ps
module testbench;
  logic mclk;
  logic resetn;
  logic outputLoadN;
  logic chainMode;
  wire frameSelN, serialClk, serialInLine, serialOutLine, serialOutOe;
  wire swCtrlStrobe, frameError, sdoPin;
  wire [15:0] dacCode, codeWord, clearcodeWord;
  wire [19:0] controlWord, swCtrlWord;
  wire [62:0] segmentSw;
  wire [9:0] ladderSw;
  int mismatches = 0;
  int samples_checked = 0;
  logic [15:0] lfsr = 16'h001b;
  logic [19:0] mdl [0:7];
  logic [47:0] rd;
  logic [47:0] w;
  logic [2:0] pend = 3'h0;
  bit armed = 1'b0;
  int errPulses = 0;
  int strobePulses = 0;

  // count one-cycle status pulses for the per-frame checks
  always @(posedge mclk) begin
    if (frameError === 1'b1) errPulses++;
    if (swCtrlStrobe === 1'b1) strobePulses++;
  end

  dsip_serial_port i_dut (.mclk, .resetn, .frameSelN, .serialClk, .serialInLine,
    .serialOutLine, .serialOutOe, .outputLoadN, .chainMode, .dacCode, .codeWord,
    .controlWord, .clearcodeWord, .swCtrlWord, .swCtrlStrobe, .frameError,
    .segmentSw, .ladderSw);
  // released output floats
  assign sdoPin = serialOutOe ? serialOutLine : 1'bz;
  dsip_host_model i_host (.frameSelN, .serialClk, .serialInLine, .serialOutLine(sdoPin));

  function automatic logic [19:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr[3:0], lfsr} & 20'hfffdf; // keeps serial output enabled
  endfunction

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one frame, then the model follows the valid ones
  task automatic xfer(input logic [47:0] fw, input int n);
    logic [2:0] a;
    logic [23:0] exp;
    bit live;
    bit ok;
    int errBefore;
    int strobeBefore;
    a = fw[22:20];
    live = armed && !mdl[2][5];
    exp = {1'b1, pend, mdl[pend]};
    errBefore = errPulses;
    strobeBefore = strobePulses;
    i_host.frame(fw, n, rd);
    repeat (8) @(posedge mclk);
    ok = n % 24 == 0 && (n == 24 || chainMode);
    if (live && n == 24) check(72'(rd[23:0]), 72'(exp));
    if (armed && mdl[2][5] && n == 24) check(72'(rd[23:0]), 72'({24{1'bz}}));
    check(72'(errPulses - errBefore), 72'(!ok));
    check(72'(strobePulses - strobeBefore), 72'(ok && !fw[23] && a == 3'h4));
    armed = 1'b0;
    if (ok) begin
      if (fw[23]) begin
        armed = a != 3'h0 && a < 3'h4;
        pend = a;
      end else if (a != 3'h0 && a < 3'h5) begin
        mdl[a] = a[0] ? {fw[19:4], 4'h0} : fw[19:0];
      end
    end
    check({codeWord, clearcodeWord, controlWord, swCtrlWord},
      {mdl[1][19:4], mdl[3][19:4], mdl[2], mdl[4]});
  endtask

  // clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    conclude();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    outputLoadN = 1'b1;
    chainMode = 1'b0;
    foreach (mdl[i]) mdl[i] = 20'h0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    check(72'(dacCode), 72'h0);
    for (int k = 0; k < 8; k++) xfer({25'h0, 3'(k % 4 + 1), rnd()}, 24);
    $display("test writes done");
    for (int k = 1; k < 5; k++) xfer({25'h1, 3'(k % 4), rnd()}, 24);
    $display("test reads done");
    xfer({25'h0, 3'h1, rnd()}, 23);
    xfer({25'h0, 3'h2, rnd()}, 25);
    $display("test lengths done");
    check(72'(dacCode), 72'h0);
    outputLoadN <= 1'b0;
    repeat (8) @(posedge mclk);
    check(72'({dacCode, ladderSw}), 72'({mdl[1][19:4], mdl[1][13:4]}));
    xfer({25'h0, 3'h1, rnd()}, 24);
    check(72'({dacCode, ladderSw}), 72'({mdl[1][19:4], mdl[1][13:4]}));
    outputLoadN <= 1'b1;
    $display("test load done");
    chainMode <= 1'b1;
    w = {1'b0, 3'h1, rnd(), 1'b0, 3'h1, rnd()};
    xfer(w, 48);
    check(72'(rd[23:0]), 72'(w[47:24]));
    chainMode <= 1'b0;
    $display("test chain done");
    xfer({25'h0, 3'h2, 20'h00020}, 24);
    xfer({25'h1, 3'h1, 20'h0}, 24);
    xfer({25'h0, 3'h2, 20'h0}, 24);
    $display("test disable done");
    conclude();
  end
endmodule

bind dsip_serial_port dsip_checker i_chk (.mclk, .resetn, .frameSelN, .serialClk,
  .serialInLine, .serialOutLine, .serialOutOe, .outputLoadN, .chainMode, .dacCode,
  .codeWord, .controlWord, .clearcodeWord, .swCtrlWord, .swCtrlStrobe, .frameError,
  .segmentSw, .ladderSw);
